// ===== ppr_pkg.sv
// Package of constants for the port pin configuration and routing block
package ppr_pkg;
  // ----------------------------------------
  // Register word indices and byte addresses
  // ----------------------------------------
  // Indices count 32-bit words, so each register sits at four times its index
  localparam logic [9:0] IDX_OPEN_DRAIN = 10'h24e;
  localparam logic [9:0] IDX_M_DATA = 10'h250;
  localparam logic [9:0] IDX_PULL_ENABLE = 10'h240;
  localparam logic [9:0] IDX_PULL_POLARITY = 10'h244;
  localparam logic [9:0] IDX_ROUTING = 10'h248;
  localparam logic [9:0] IDX_S_DIRECTION = 10'h24a;
  localparam logic [9:0] IDX_M_DIRECTION = 10'h254;
  localparam logic [9:0] IDX_S_DATA = 10'h258;
  localparam logic [9:0] IDX_EDGE_FLAGS = 10'h25c;
  localparam logic [11:0] ADDR_OPEN_DRAIN = {IDX_OPEN_DRAIN, 2'b00};
  localparam logic [11:0] ADDR_M_DATA = {IDX_M_DATA, 2'b00};
  localparam logic [11:0] ADDR_PULL_ENABLE = {IDX_PULL_ENABLE, 2'b00};
  localparam logic [11:0] ADDR_PULL_POLARITY = {IDX_PULL_POLARITY, 2'b00};
  localparam logic [11:0] ADDR_ROUTING = {IDX_ROUTING, 2'b00};
  localparam logic [11:0] ADDR_S_DIRECTION = {IDX_S_DIRECTION, 2'b00};
  localparam logic [11:0] ADDR_M_DIRECTION = {IDX_M_DIRECTION, 2'b00};
  localparam logic [11:0] ADDR_S_DATA = {IDX_S_DATA, 2'b00};
  localparam logic [11:0] ADDR_EDGE_FLAGS = {IDX_EDGE_FLAGS, 2'b00};
  // ----------------------------------------
  // Reset values and fields
  // ----------------------------------------
  localparam logic [7:0] RST_PULL_ENABLE = 8'hff;
  localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [3:0] RST_M_DATA = 4'h0;
  localparam int IIC_LO = 0;
  localparam int SPI_LO = 4;
  localparam int IIC_SCL_PIN = 4;
  localparam int IIC_SDA_PIN = 7;
  localparam int SPI_FIRST_PIN = 4;
  localparam logic [1:0] SPI_ON_S = 2'h0;
  localparam logic [1:0] SPI_RESERVED = 2'h3;
  localparam logic [1:0] IIC_ALT1 = 2'h2;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RESP = 3'b010,
    ST_WAIT = 3'b100
  } ppr_wr_t;
endpackage

// ===== ppr_sync.sv
// Two-stage input synchroniser with edge detection on the settled sample
`timescale 1ns/1ps
module ppr_sync import ppr_pkg::*; #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins and results
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] synced,
  output logic [WIDTH-1:0] rose,
  output logic [WIDTH-1:0] fell
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] prev;
  initial begin
    if (WIDTH < 1) $error("WIDTH must be positive");
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Pulled-up idle level, so no false edge right after reset
      stage1 <= '1;
      synced <= '1;
      prev <= '1;
    end else begin
      stage1 <= pin_in;
      synced <= stage1;
      prev <= synced;
    end
  end
  assign rose = synced & ~prev;
  assign fell = ~synced & prev;
endmodule

// ===== ppr_pad.sv
// Per-pin pad control: direction, drive style and pull devices
`timescale 1ns/1ps
module ppr_pad import ppr_pkg::*; #(
  parameter int WIDTH = 8
) (
  // Pin configuration
  input wire logic [WIDTH-1:0] dir_out,
  input wire logic [WIDTH-1:0] out_val,
  input wire logic [WIDTH-1:0] open_drain,
  input wire logic [WIDTH-1:0] pull_en,
  input wire logic [WIDTH-1:0] pull_down_sel,
  // Pad controls
  output logic [WIDTH-1:0] pad_o,
  output logic [WIDTH-1:0] pad_oe,
  output logic [WIDTH-1:0] pull_up,
  output logic [WIDTH-1:0] pull_down
);
  wire [WIDTH-1:0] od_eff = open_drain & dir_out;
  assign pad_o = out_val & ~od_eff;
  assign pad_oe = dir_out & ~(od_eff & out_val);
  assign pull_up = pull_en & ~dir_out & ~pull_down_sel;
  assign pull_down = pull_en & ~dir_out & pull_down_sel;
endmodule

// ===== ppr_top.sv
// Port pin configuration and routing block with an AXI4-Lite register slave
`timescale 1ns/1ps
module ppr_top import ppr_pkg::*; #(
  parameter int S_PINS = 8,
  parameter int M_PINS = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // First port pins
  input wire logic [S_PINS-1:0] s_pin_i,
  output logic [S_PINS-1:0] s_pin_o,
  output logic [S_PINS-1:0] s_pin_oe,
  output logic [S_PINS-1:0] s_pull_up,
  output logic [S_PINS-1:0] s_pull_down,
  // Second port pins
  input wire logic [M_PINS-1:0] m_pin_i,
  output logic [M_PINS-1:0] m_pin_o,
  output logic [M_PINS-1:0] m_pin_oe,
  // Peripheral hookup
  input wire logic iic_enable,
  input wire logic iic_scl_o,
  input wire logic iic_sda_o,
  input wire logic spi_enable,
  input wire logic [3:0] spi_o,
  input wire logic [3:0] spi_oe,
  input wire logic [1:0] timer_oc_enable,
  input wire logic [1:0] timer_oc_val,
  input wire logic [1:0] pwm_enable,
  input wire logic [1:0] pwm_val,
  output logic [S_PINS-1:0] s_pin_sync,
  output logic [S_PINS-1:0] s_edge_pulse,
  output logic [1:0] iic_route,
  output logic [1:0] spi_route
);
  initial begin
    if (S_PINS != 8) $error("S_PINS must be 8");
    if (M_PINS != 4) $error("M_PINS must be 4");
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] first_port_pull_enable;
  logic [7:0] first_port_pull_polarity;
  logic [7:0] first_port_open_drain_select;
  logic [7:0] first_port_routing_select;
  logic [7:0] first_port_direction;
  logic [7:0] first_port_data;
  logic [7:0] first_port_edge_flags;
  logic [3:0] second_port_data;
  logic [3:0] second_port_direction;
  ppr_wr_t wr_state;
  logic [11:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [7:0] s_sync;
  logic [7:0] s_rise;
  logic [7:0] s_fall;
  logic [3:0] m_sync;
  ppr_sync #(.WIDTH(8)) u_sync_s (
    .aclk(aclk), .aresetn(aresetn), .pin_in(s_pin_i),
    .synced(s_sync), .rose(s_rise), .fell(s_fall)
  );
  ppr_sync #(.WIDTH(4)) u_sync_m (
    .aclk(aclk), .aresetn(aresetn), .pin_in(m_pin_i),
    .synced(m_sync), .rose(), .fell()
  );
  // Polarity picks which edge counts
  wire [7:0] edge_hit = (s_rise & first_port_pull_polarity) |
    (s_fall & ~first_port_pull_polarity);

  // ----------------------------------------
  // Routing and pin ownership
  // ----------------------------------------
  wire [1:0] iic_sel = first_port_routing_select[IIC_LO +: 2];
  wire [1:0] spi_sel = first_port_routing_select[SPI_LO +: 2];
  wire iic_here = iic_enable && (iic_sel < IIC_ALT1);
  wire spi_here = spi_enable && (spi_sel == SPI_ON_S);
  logic [7:0] s_dir_eff;
  logic [7:0] s_val_eff;
  logic [7:0] s_od_eff;
  always_comb begin
    s_dir_eff = first_port_direction;
    s_val_eff = first_port_data;
    s_od_eff = first_port_open_drain_select;
    if (iic_here) begin
      // Two-wire bus needs wired-or whatever software chose
      s_dir_eff[IIC_SCL_PIN] = 1'b1;
      s_dir_eff[IIC_SDA_PIN] = 1'b1;
      s_val_eff[IIC_SCL_PIN] = iic_scl_o;
      s_val_eff[IIC_SDA_PIN] = iic_sda_o;
      s_od_eff[IIC_SCL_PIN] = 1'b1;
      s_od_eff[IIC_SDA_PIN] = 1'b1;
    end
    if (spi_here) begin
      // SPI outranks the two-wire bus on shared pins
      s_dir_eff[SPI_FIRST_PIN +: 4] = spi_oe;
      s_val_eff[SPI_FIRST_PIN +: 4] = spi_o;
      s_od_eff[SPI_FIRST_PIN +: 4] = first_port_open_drain_select[SPI_FIRST_PIN +: 4];
    end
  end
  logic [7:0] s_o_c;
  logic [7:0] s_oe_c;
  logic [7:0] s_pu_c;
  logic [7:0] s_pd_c;
  ppr_pad #(.WIDTH(8)) u_pad_s (
    .dir_out(s_dir_eff), .out_val(s_val_eff), .open_drain(s_od_eff),
    .pull_en(first_port_pull_enable), .pull_down_sel(first_port_pull_polarity),
    .pad_o(s_o_c), .pad_oe(s_oe_c), .pull_up(s_pu_c), .pull_down(s_pd_c)
  );

  // Second port: timer beats PWM beats GPIO on pins 3 and 2
  logic [3:0] m_dir_eff;
  logic [3:0] m_val_eff;
  always_comb begin
    m_dir_eff = second_port_direction;
    m_val_eff = second_port_data;
    for (int i = 0; i < 2; i++) begin
      if (timer_oc_enable[i]) begin
        m_dir_eff[2+i] = 1'b1;
        m_val_eff[2+i] = timer_oc_val[i];
      end else if (pwm_enable[i]) begin
        m_dir_eff[2+i] = 1'b1;
        m_val_eff[2+i] = pwm_val[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_pin_o <= '0;
      s_pin_oe <= '0;
      s_pull_up <= '1;
      s_pull_down <= '0;
      m_pin_o <= '0;
      m_pin_oe <= '0;
      s_pin_sync <= '0;
      s_edge_pulse <= '0;
      iic_route <= '0;
      spi_route <= '0;
    end else begin
      s_pin_o <= s_o_c;
      s_pin_oe <= s_oe_c;
      s_pull_up <= s_pu_c;
      s_pull_down <= s_pd_c;
      m_pin_o <= m_val_eff & m_dir_eff;
      m_pin_oe <= m_dir_eff;
      s_pin_sync <= s_sync;
      s_edge_pulse <= edge_hit;
      iic_route <= iic_sel;
      spi_route <= spi_sel;
    end
  end

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire [11:0] wa = aw_take ? s_axi_awaddr : aw_addr;
  wire [31:0] wd = w_take ? s_axi_wdata : w_data;
  wire [3:0] ws = w_take ? s_axi_wstrb : w_strb;
  wire have_aw = aw_take || aw_held;
  wire have_w = w_take || w_held;
  wire do_write = (wr_state == ST_IDLE) && have_aw && have_w;
  wire wr_lane0 = do_write && ws[0];
  wire wr_known = (wa == ADDR_PULL_ENABLE) || (wa == ADDR_PULL_POLARITY) ||
    (wa == ADDR_OPEN_DRAIN) || (wa == ADDR_ROUTING) || (wa == ADDR_S_DIRECTION) ||
    (wa == ADDR_S_DATA) || (wa == ADDR_M_DATA) || (wa == ADDR_M_DIRECTION) ||
    (wa == ADDR_EDGE_FLAGS);
  wire [7:0] flag_clr = (wr_lane0 && wa == ADDR_EDGE_FLAGS) ? wd[7:0] : 8'h00;
  // Set wins over a clear in the same cycle
  wire [7:0] next_flags = (first_port_edge_flags & ~flag_clr) | edge_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= ST_IDLE;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      case (wr_state)
        ST_IDLE: begin
          s_axi_awready <= !have_aw;
          s_axi_wready <= !have_w;
          if (aw_take) begin
            aw_addr <= s_axi_awaddr;
            aw_held <= 1'b1;
          end
          if (w_take) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_held <= 1'b1;
          end
          if (do_write) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? AXI_OKAY : AXI_SLVERR;
            wr_state <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          s_axi_awready <= 1'b1;
          s_axi_wready <= 1'b1;
          wr_state <= ST_IDLE;
        end
        default: wr_state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_port_pull_enable <= RST_PULL_ENABLE;
      first_port_open_drain_select <= RST_OPEN_DRAIN;
      first_port_pull_polarity <= RST_ZERO;
      first_port_routing_select <= RST_ZERO;
      first_port_direction <= RST_ZERO;
      first_port_data <= RST_ZERO;
      first_port_edge_flags <= RST_ZERO;
      second_port_data <= RST_M_DATA;
      second_port_direction <= '0;
    end else begin
      first_port_edge_flags <= next_flags;
      if (wr_lane0) begin
        case (wa)
          ADDR_PULL_ENABLE: first_port_pull_enable <= wd[7:0];
          ADDR_PULL_POLARITY: first_port_pull_polarity <= wd[7:0];
          ADDR_OPEN_DRAIN: first_port_open_drain_select <= wd[7:0];
          ADDR_ROUTING: first_port_routing_select <= wd[7:0] & 8'h33;
          ADDR_S_DIRECTION: first_port_direction <= wd[7:0];
          ADDR_S_DATA: first_port_data <= wd[7:0];
          ADDR_M_DATA: second_port_data <= wd[3:0];
          ADDR_M_DIRECTION: second_port_direction <= wd[3:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  // Read-back uses the synchronised pin, so it lags by two edges
  wire [3:0] m_read = (second_port_direction & second_port_data) |
    (~second_port_direction & m_sync);
  wire [7:0] s_read = (first_port_direction & first_port_data) |
    (~first_port_direction & s_sync);
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      ADDR_PULL_ENABLE: rd_word = {24'h0, first_port_pull_enable};
      ADDR_PULL_POLARITY: rd_word = {24'h0, first_port_pull_polarity};
      ADDR_OPEN_DRAIN: rd_word = {24'h0, first_port_open_drain_select};
      ADDR_ROUTING: rd_word = {24'h0, first_port_routing_select};
      ADDR_S_DIRECTION: rd_word = {24'h0, first_port_direction};
      ADDR_S_DATA: rd_word = {24'h0, s_read};
      ADDR_EDGE_FLAGS: rd_word = {24'h0, first_port_edge_flags};
      ADDR_M_DATA: rd_word = {28'h0, m_read};
      ADDR_M_DIRECTION: rd_word = {28'h0, second_port_direction};
      default: begin
        rd_word = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  pull_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_pull_up | s_pull_down) == ($past(first_port_pull_enable) & ~$past(s_dir_eff)))
    else $error("pull active outside enabled input");
  pull_pol_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_pull_down & ~$past(first_port_pull_polarity)) == 8'h00)
    else $error("pull-down with polarity 0");
  pull_up_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_pull_up & $past(first_port_pull_polarity)) == 8'h00)
    else $error("pull-up with polarity 1");
  od_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_pin_oe & s_pin_o & $past(s_od_eff)) == 8'h00)
    else $error("open-drain pin driven high");
  pp_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_pin_oe == $past(s_dir_eff & ~(s_od_eff & s_val_eff))))
    else $error("output enable mismatch");
  m_timer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(timer_oc_enable[0]) |-> m_pin_oe[2] && m_pin_o[2] == $past(timer_oc_val[0]))
    else $error("timer output lost pin 2");
  m_pwm_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(pwm_enable[1] && !timer_oc_enable[1]) |-> m_pin_o[3] == $past(pwm_val[1]))
    else $error("pwm output lost pin 3");
  flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    |edge_hit |=> |(first_port_edge_flags & $past(edge_hit)))
    else $error("edge flag not set");
  iic_od_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(iic_here && !spi_here) |-> !(s_pin_oe[IIC_SDA_PIN] && s_pin_o[IIC_SDA_PIN]))
    else $error("two-wire pin driven high");
  m_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_axi_rvalid) && $past(s_axi_araddr) == ADDR_M_DATA |-> s_axi_rdata[31:4] == 28'h0)
    else $error("unused data bits not zero");
  wr_cov: cover property (@(posedge aclk) do_write && wr_known);
  rd_cov: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
  edge_cov: cover property (@(posedge aclk) |edge_hit);
endmodule

// ===== ppr_pin_model.sv
// Far-side model of the port pins: outside drivers, pad drive and pull devices
`timescale 1ns/1ps
module ppr_pin_model (
  // Clock
  input wire logic aclk,
  // Pad side of the block
  input wire logic [7:0] s_pin_o,
  input wire logic [7:0] s_pin_oe,
  input wire logic [7:0] s_pull_up,
  input wire logic [7:0] s_pull_down,
  input wire logic [3:0] m_pin_o,
  input wire logic [3:0] m_pin_oe,
  // Outside drivers
  input wire logic [7:0] ext_s_val,
  input wire logic [7:0] ext_s_en,
  input wire logic [3:0] ext_m_val,
  input wire logic [3:0] ext_m_en,
  // Resolved levels
  output logic [7:0] s_level,
  output logic [3:0] m_level
);
  logic float_pat = 1'b0;
  // Undriven unpulled pins wander, so a stale level never passes for a drive
  always @(posedge aclk) float_pat <= ~float_pat;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (ext_s_en[i]) s_level[i] = ext_s_val[i];
      else if (s_pin_oe[i]) s_level[i] = s_pin_o[i];
      else if (s_pull_down[i]) s_level[i] = 1'b0;
      else if (s_pull_up[i]) s_level[i] = 1'b1;
      else s_level[i] = float_pat;
    end
    for (int j = 0; j < 4; j++) begin
      if (ext_m_en[j]) m_level[j] = ext_m_val[j];
      else if (m_pin_oe[j]) m_level[j] = m_pin_o[j];
      else m_level[j] = float_pat;
    end
  end
endmodule

// ===== tb.sv
// Self-checking testbench for the port pin configuration and routing block
`timescale 1ns/1ps
module tb import ppr_pkg::*;;
  logic aclk, aresetn;
  logic [11:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] s_pin_i, s_pin_o, s_pin_oe, s_pull_up, s_pull_down, s_pin_sync, s_edge_pulse;
  logic [3:0] m_pin_i, m_pin_o, m_pin_oe;
  logic iic_enable, iic_scl_o, iic_sda_o, spi_enable;
  logic [3:0] spi_o, spi_oe, ext_m_val, ext_m_en;
  logic [1:0] timer_oc_enable, timer_oc_val, pwm_enable, pwm_val, iic_route, spi_route;
  logic [7:0] ext_s_val, ext_s_en;
  int failures = 0;
  int samples_checked = 0;
  ppr_top dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_pin_i(s_pin_i), .s_pin_o(s_pin_o), .s_pin_oe(s_pin_oe), .s_pull_up(s_pull_up),
    .s_pull_down(s_pull_down), .m_pin_i(m_pin_i), .m_pin_o(m_pin_o), .m_pin_oe(m_pin_oe),
    .iic_enable(iic_enable), .iic_scl_o(iic_scl_o), .iic_sda_o(iic_sda_o),
    .spi_enable(spi_enable), .spi_o(spi_o), .spi_oe(spi_oe),
    .timer_oc_enable(timer_oc_enable), .timer_oc_val(timer_oc_val),
    .pwm_enable(pwm_enable), .pwm_val(pwm_val), .s_pin_sync(s_pin_sync),
    .s_edge_pulse(s_edge_pulse), .iic_route(iic_route), .spi_route(spi_route));
  ppr_pin_model pins (.aclk(aclk), .s_pin_o(s_pin_o), .s_pin_oe(s_pin_oe),
    .s_pull_up(s_pull_up), .s_pull_down(s_pull_down), .m_pin_o(m_pin_o),
    .m_pin_oe(m_pin_oe), .ext_s_val(ext_s_val), .ext_s_en(ext_s_en),
    .ext_m_val(ext_m_val), .ext_m_en(ext_m_en), .s_level(s_pin_i), .m_level(m_pin_i));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      failures++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Write one register; both channels offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1) && n < 100);
    bready <= 1'b0;
    chk("bvalid", 32'h1, {31'h0, bvalid});
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1) && n < 100);
    rready <= 1'b0;
    chk("rvalid", 32'h1, {31'h0, rvalid});
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    chk("rdata", ed, rdata);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("pull_up", 8'hff, s_pull_up);
    chk("pull_down", 8'h00, s_pull_down);
    chk("s_oe", 8'h00, s_pin_oe);
    chk("m_oe", 4'h0, m_pin_oe);
    rd(ADDR_PULL_ENABLE, 32'hff, AXI_OKAY);
    rd(ADDR_OPEN_DRAIN, 32'h00, AXI_OKAY);
    // Output direction makes the read show the register, not the pins
    wr(ADDR_M_DIRECTION, 8'h0f, AXI_OKAY);
    rd(ADDR_M_DATA, 32'h00, AXI_OKAY);
    wr(ADDR_M_DIRECTION, 8'h00, AXI_OKAY);
  endtask
  task automatic t_pull();
    wr(ADDR_PULL_POLARITY, 8'h0f, AXI_OKAY);
    cyc(2);
    chk("pull_down", 8'h0f, s_pull_down);
    chk("pull_up", 8'hf0, s_pull_up);
    wr(ADDR_PULL_ENABLE, 8'h3c, AXI_OKAY);
    wr(ADDR_S_DIRECTION, 8'h0c, AXI_OKAY);
    cyc(2);
    // Output pins lose their pull even when enabled
    chk("pull_down", 8'h00, s_pull_down);
    chk("pull_up", 8'h30, s_pull_up);
    rd(ADDR_PULL_POLARITY, 32'h0f, AXI_OKAY);
    wr(ADDR_S_DIRECTION, 8'h00, AXI_OKAY);
    wr(ADDR_PULL_ENABLE, 8'hff, AXI_OKAY);
  endtask
  task automatic t_edge();
    // Let earlier floating-pin edges drain before clearing
    cyc(5);
    wr(ADDR_EDGE_FLAGS, 8'hff, AXI_OKAY);
    rd(ADDR_EDGE_FLAGS, 32'h00, AXI_OKAY);
    ext_s_en <= 8'h81;
    ext_s_val <= 8'h01;
    cyc(4);
    chk("edge_pulse", 8'h81, s_edge_pulse);
    cyc(2);
    chk("pin_sync", 8'h71, s_pin_sync);
    rd(ADDR_EDGE_FLAGS, 32'h81, AXI_OKAY);
    rd(ADDR_S_DATA, 32'h71, AXI_OKAY);
    wr(ADDR_EDGE_FLAGS, 8'hff, AXI_OKAY);
    ext_s_en <= 8'h00;
    cyc(6);
    // Pulls now make the opposite edges, which must not set flags
    rd(ADDR_EDGE_FLAGS, 32'h00, AXI_OKAY);
  endtask
  task automatic t_open_drain();
    wr(ADDR_S_DIRECTION, 8'hff, AXI_OKAY);
    wr(ADDR_S_DATA, 8'h0f, AXI_OKAY);
    wr(ADDR_OPEN_DRAIN, 8'h33, AXI_OKAY);
    cyc(2);
    chk("s_oe", 8'hfc, s_pin_oe);
    chk("s_o", 8'h0c, s_pin_o & s_pin_oe);
    wr(ADDR_S_DIRECTION, 8'h0f, AXI_OKAY);
    cyc(2);
    chk("s_oe_in", 8'h0c, s_pin_oe);
    rd(ADDR_OPEN_DRAIN, 32'h33, AXI_OKAY);
    wr(ADDR_OPEN_DRAIN, 8'h00, AXI_OKAY);
    wr(ADDR_S_DIRECTION, 8'h00, AXI_OKAY);
  endtask
  task automatic t_routing();
    logic [7:0] v;
    for (int k = 0; k < 4; k++) begin
      v = 8'(8'h11 * k);
      wr(ADDR_ROUTING, v, AXI_OKAY);
      cyc(2);
      chk("iic_route", v[1:0], iic_route);
      chk("spi_route", v[5:4], spi_route);
      rd(ADDR_ROUTING, {24'h0, v}, AXI_OKAY);
    end
    wr(ADDR_ROUTING, 8'h00, AXI_OKAY);
    spi_enable <= 1'b1;
    spi_oe <= 4'hf;
    spi_o <= 4'h5;
    cyc(3);
    chk("spi_oe", 4'hf, s_pin_oe[7:4]);
    chk("spi_o", 4'h5, s_pin_o[7:4]);
    wr(ADDR_ROUTING, 8'h10, AXI_OKAY);
    iic_enable <= 1'b1;
    iic_scl_o <= 1'b1;
    iic_sda_o <= 1'b0;
    cyc(3);
    chk("iic_oe", 4'h8, s_pin_oe[7:4]);
    chk("iic_sda", 1'b0, s_pin_o[7]);
    wr(ADDR_ROUTING, 8'h12, AXI_OKAY);
    cyc(2);
    chk("off_oe", 4'h0, s_pin_oe[7:4]);
    iic_enable <= 1'b0;
    spi_enable <= 1'b0;
  endtask
  task automatic t_mport();
    wr(ADDR_M_DIRECTION, 8'h0f, AXI_OKAY);
    wr(ADDR_M_DATA, 8'hf5, AXI_OKAY);
    cyc(2);
    chk("m_oe", 4'hf, m_pin_oe);
    chk("m_o", 4'h5, m_pin_o);
    rd(ADDR_M_DATA, 32'h05, AXI_OKAY);
    pwm_enable <= 2'b11;
    pwm_val <= 2'b10;
    cyc(3);
    chk("m_pwm", 2'b10, m_pin_o[3:2]);
    timer_oc_enable <= 2'b01;
    timer_oc_val <= 2'b01;
    cyc(3);
    chk("m_timer", 2'b11, m_pin_o[3:2]);
    pwm_enable <= 2'b00;
    timer_oc_enable <= 2'b00;
    wr(ADDR_M_DIRECTION, 8'h00, AXI_OKAY);
    ext_m_en <= 4'hf;
    ext_m_val <= 4'h6;
    cyc(4);
    chk("m_oe_in", 4'h0, m_pin_oe);
    rd(ADDR_M_DATA, 32'h06, AXI_OKAY);
  endtask
  task automatic t_unmapped();
    wr(12'h3f0, 8'ha5, AXI_SLVERR);
    rd(12'h3f0, 32'h0, AXI_SLVERR);
    wstrb <= 4'h0;
    wr(ADDR_PULL_POLARITY, 8'h55, AXI_OKAY);
    wstrb <= 4'h1;
    rd(ADDR_PULL_POLARITY, 32'h0f, AXI_OKAY);
  endtask
  task automatic final_report();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    final_report();
  end
  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'h1;
    {iic_enable, iic_scl_o, iic_sda_o, spi_enable} = '0;
    {spi_o, spi_oe, ext_m_val, ext_m_en, ext_s_val, ext_s_en} = '0;
    {timer_oc_enable, timer_oc_val, pwm_enable, pwm_val} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_pull();
    t_edge();
    t_open_drain();
    t_routing();
    t_mport();
    t_unmapped();
    final_report();
  end
endmodule
